// File: include/sqe_pkg.sv
package sqe_pkg;

    typedef enum logic [1:0] {SQE_WAIT, SQE_FETCH, SQE_LOAD, SQE_RUN} sqe_fsm_e;

    // One state definition; inputs are {warning, status[9:0]}
    typedef struct packed {
        logic        to_en;
        logic [15:0] to_dly;
        logic [5:0]  to_next;
        logic [5:0]  mon_next;
        logic        mon_pol;
        logic [10:0] mon_mask;
        logic [5:0]  seq_next;
        logic [15:0] seq_dly;
        logic        seq_pol;
        logic [10:0] seq_mask;
        logic [9:0]  outs;
    } sqe_def_s;

endpackage

// File: include/sqe_regs.svh
`ifndef SQE_REGS_SVH
`define SQE_REGS_SVH

// ==========================================
// Register byte addresses
`define SQE_A_SRC      8'h00
`define SQE_A_HOST     8'h04
`define SQE_A_STYLE    8'h08
`define SQE_A_JUMP     8'h0C
`define SQE_A_STAT     8'h10
`define SQE_A_MEMW0    8'h14
`define SQE_A_MEMW1    8'h18
`define SQE_A_MEMW2    8'h1C
`define SQE_A_MEMADDR  8'h20

// ==========================================
// Reset values and fields
`define SQE_SRC_RST    20'h00000
`define SQE_HOST_RST   10'h000
`define SQE_STYLE_RST  30'h00000000
`define SQE_JUMP_BIT   0
`define SQE_ENTRY      6'h00
`define SQE_N_CP       6

// ==========================================
// Output data sources
`define SQE_SRC_ENG    2'h0
`define SQE_SRC_HOST   2'h1
`define SQE_SRC_OSC    2'h2

// ==========================================
// Drive styles
`define SQE_STY_OD     3'h0
`define SQE_STY_ODPU   3'h1
`define SQE_STY_PP     3'h2
`define SQE_STY_SPD    3'h3
`define SQE_STY_CP     3'h4

// ==========================================
// Timing
`define SQE_CLK_HZ     250000000
`define SQE_OSC_HZ     100000
`define SQE_TICK_CYC   (`SQE_CLK_HZ / `SQE_OSC_HZ)
`define SQE_HALF_CYC   (`SQE_TICK_CYC / 2)
`define SQE_TRANS_US   20
`define SQE_DLY_MAX_MS 400
`define SQE_DLY_MAX    (`SQE_DLY_MAX_MS * (`SQE_OSC_HZ / 1000))

`endif

// File: rtl/sqe_def_mem.sv
`timescale 1ns/1ps
`default_nettype none

module sqe_def_mem #(
    parameter int W     = 85,
    parameter int DEPTH = 63,
    parameter int AW    = 6
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_n,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data
);

    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge mclk) begin
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Address at or past DEPTH reads as an all-zero definition; unwritten slots are not cleared
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= (32'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
        end
    end

endmodule // sqe_def_mem

`default_nettype wire

// File: rtl/sqe_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "sqe_regs.svh"

module sqe_engine #(
    parameter int TRANS_CYC = `SQE_TRANS_US * (`SQE_CLK_HZ / 1000000)
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Filtered inputs and configuration
    input  wire logic [9:0]  sfd_status,
    input  wire logic [5:0]  warn_in,
    input  wire logic        config_done,
    // Programmable outputs
    output logic      [9:0]  prog_out_lvl,
    output logic      [9:0]  prog_out_oe,
    output logic      [9:0]  prog_out_weak_pd,
    output logic      [29:0] prog_out_style
);

    // ==========================================
    // Reset release
    logic rst_s1, rst_n;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ==========================================
    // Input synchronisers, change taken when stages 2 and 3 agree
    logic [16:0] sy1, sy2, sy3, in_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sy1  <= '0;
            sy2  <= '0;
            sy3  <= '0;
            in_q <= '0;
        end else begin
            sy1  <= {config_done, warn_in, sfd_status};
            sy2  <= sy1;
            sy3  <= sy2;
            in_q <= (sy2 & sy3) | (in_q & (sy2 ^ sy3));
        end
    end

    logic        cfg_ok;
    logic [10:0] in_vec;
    assign cfg_ok = in_q[16];
    assign in_vec = {|in_q[15:10], in_q[9:0]};

    // ==========================================
    // Registers
    logic [19:0] src_reg;
    logic [9:0]  host_reg;
    logic [29:0] style_reg;
    logic [31:0] memw0_reg, memw1_reg;
    logic [20:0] memw2_reg;
    logic        jump_reg;
    logic [5:0]  cur_reg;
    logic        exit_any;
    sqe_pkg::sqe_fsm_e fsm_reg;

    logic wr_jump, wr_commit;
    assign wr_jump   = reg_wr && reg_addr == `SQE_A_JUMP && reg_wdata[`SQE_JUMP_BIT];
    assign wr_commit = reg_wr && reg_addr == `SQE_A_MEMADDR;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_reg   <= `SQE_SRC_RST;
            host_reg  <= `SQE_HOST_RST;
            style_reg <= `SQE_STYLE_RST;
            memw0_reg <= '0;
            memw1_reg <= '0;
            memw2_reg <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `SQE_A_SRC:   src_reg   <= reg_wdata[19:0];
                `SQE_A_HOST:  host_reg  <= reg_wdata[9:0];
                `SQE_A_STYLE: style_reg <= reg_wdata[29:0];
                `SQE_A_MEMW0: memw0_reg <= reg_wdata;
                `SQE_A_MEMW1: memw1_reg <= reg_wdata;
                `SQE_A_MEMW2: memw2_reg <= reg_wdata[20:0];
                default: ;
            endcase
        end
    end

    // Pending jump; a new command wins over consumption
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            jump_reg <= 1'b0;
        end else begin
            jump_reg <= wr_jump || (jump_reg && !(fsm_reg == sqe_pkg::SQE_RUN && exit_any));
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `SQE_A_SRC:   reg_rdata <= {12'h000, src_reg};
                `SQE_A_HOST:  reg_rdata <= {22'h000000, host_reg};
                `SQE_A_STYLE: reg_rdata <= {2'h0, style_reg};
                `SQE_A_JUMP:  reg_rdata <= {31'h00000000, jump_reg};
                `SQE_A_STAT:  reg_rdata <= {14'h0000, in_vec, fsm_reg == sqe_pkg::SQE_RUN, cur_reg};
                default:      reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ==========================================
    // Definition memory
    logic [84:0] mem_rdata;
    sqe_def_mem #(.W(85), .DEPTH(63), .AW(6)) u_mem (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_en   (wr_commit),
        .wr_addr (reg_wdata[5:0]),
        .wr_data ({memw2_reg, memw1_reg, memw0_reg}),
        .rd_en   (fsm_reg == sqe_pkg::SQE_FETCH),
        .rd_addr (cur_reg),
        .rd_data (mem_rdata)
    );

    // ==========================================
    // Oscillator tick and 100 kHz clock
    logic [11:0] tick_cnt;
    logic        osc_reg, tick;
    assign tick = tick_cnt == 12'(`SQE_TICK_CYC - 1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            osc_reg  <= 1'b0;
        end else begin
            tick_cnt <= tick ? 12'h000 : tick_cnt + 12'h001;
            if (tick || tick_cnt == 12'(`SQE_HALF_CYC - 1)) begin
                osc_reg <= !osc_reg;
            end
        end
    end

    // ==========================================
    // State timer in oscillator periods
    sqe_pkg::sqe_def_s def_reg;
    logic [15:0]       tmr_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_reg <= '0;
        end else if (fsm_reg == sqe_pkg::SQE_LOAD) begin
            tmr_reg <= '0;
        end else if (tick && tmr_reg != 16'(`SQE_DLY_MAX)) begin
            tmr_reg <= tmr_reg + 16'h0001;
        end
    end

    // ==========================================
    // Exit evaluation
    logic       seq_ok, seq_fire, to_fire, mon_fire;
    logic [5:0] exit_tgt;
    always_comb begin
        seq_ok   = &(~def_reg.seq_mask | (in_vec ^ {11{!def_reg.seq_pol}}));
        mon_fire = |(def_reg.mon_mask & (in_vec ^ {11{def_reg.mon_pol}}));
        // Jump takes the sequence path and holds the timeout off
        to_fire  = def_reg.to_en && tmr_reg >= def_reg.to_dly && !seq_ok && !jump_reg;
        seq_fire = (seq_ok && tmr_reg >= def_reg.seq_dly) || jump_reg;
        exit_any = mon_fire || to_fire || seq_fire;
        if (mon_fire) begin
            exit_tgt = def_reg.mon_next;
        end else if (to_fire) begin
            exit_tgt = def_reg.to_next;
        end else begin
            exit_tgt = def_reg.seq_next;
        end
    end

    // ==========================================
    // Sequencing state machine
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fsm_reg <= sqe_pkg::SQE_WAIT;
        end else begin
            case (fsm_reg)
                sqe_pkg::SQE_WAIT:  if (cfg_ok) fsm_reg <= sqe_pkg::SQE_FETCH;
                sqe_pkg::SQE_FETCH: fsm_reg <= sqe_pkg::SQE_LOAD;
                sqe_pkg::SQE_LOAD:  fsm_reg <= sqe_pkg::SQE_RUN;
                sqe_pkg::SQE_RUN:   if (exit_any) fsm_reg <= sqe_pkg::SQE_FETCH;
                default:            fsm_reg <= sqe_pkg::SQE_WAIT;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= `SQE_ENTRY;
        end else if (fsm_reg == sqe_pkg::SQE_RUN && exit_any) begin
            cur_reg <= exit_tgt;
        end
    end

    // Old levels stay until the new definition lands
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            def_reg <= '0;
        end else if (fsm_reg == sqe_pkg::SQE_LOAD) begin
            def_reg <= sqe_pkg::sqe_def_s'(mem_rdata);
        end
    end

    // ==========================================
    // Output stage; one register process so each output has a single driver
    logic [9:0]  lvl_v;
    logic [9:0]  oe_v;
    logic [29:0] sty_v;
    for (genvar i = 0; i < 10; i++) begin : g_out
        assign sty_v[3*i +: 3] = (i >= `SQE_N_CP && style_reg[3*i +: 3] == `SQE_STY_CP)
                               ? `SQE_STY_OD : style_reg[3*i +: 3];
        assign lvl_v[i] = (src_reg[2*i +: 2] == `SQE_SRC_HOST) ? host_reg[i] :
                          (src_reg[2*i +: 2] == `SQE_SRC_OSC)  ? osc_reg :
                          def_reg.outs[i];
        assign oe_v[i]  = !lvl_v[i] || sty_v[3*i +: 3] == `SQE_STY_PP
                          || sty_v[3*i +: 3] == `SQE_STY_CP;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prog_out_lvl     <= '0;
            prog_out_oe      <= '0;
            prog_out_weak_pd <= '1;
            prog_out_style   <= {10{`SQE_STY_OD}};
        end else begin
            // Pre-configuration: only the weak pull-down acts
            prog_out_lvl     <= cfg_ok ? lvl_v : '0;
            prog_out_oe      <= cfg_ok ? oe_v : '0;
            prog_out_weak_pd <= {10{!cfg_ok}};
            prog_out_style   <= sty_v;
        end
    end

    // ==========================================
    // Checks
    int trans_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trans_cnt <= 0;
        end else begin
            trans_cnt <= (fsm_reg == sqe_pkg::SQE_RUN || !cfg_ok) ? 0 : trans_cnt + 1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_TRANS_TIME: assert property (trans_cnt < TRANS_CYC)
        else $error("state change too slow");
    AST_MON_FIRST: assert property (fsm_reg == sqe_pkg::SQE_RUN && mon_fire
        |=> cur_reg == $past(def_reg.mon_next) ##2 fsm_reg == sqe_pkg::SQE_RUN)
        else $error("monitor exit not taken");
    AST_TO_EXIT: assert property (fsm_reg == sqe_pkg::SQE_RUN && !mon_fire && to_fire
        |=> cur_reg == $past(def_reg.to_next))
        else $error("timeout exit wrong");
    AST_JUMP_SEQ: assert property (fsm_reg == sqe_pkg::SQE_RUN && jump_reg && !mon_fire
        |=> cur_reg == $past(def_reg.seq_next) && (!jump_reg || $past(wr_jump)))
        else $error("jump not taken");
    AST_OUT_HOLD: assert property (fsm_reg == sqe_pkg::SQE_RUN
        && $past(fsm_reg) == sqe_pkg::SQE_RUN |-> $stable(def_reg.outs))
        else $error("state levels moved");
    AST_TMR_RST: assert property (fsm_reg == sqe_pkg::SQE_LOAD
        |=> tmr_reg == 16'h0000 ##1 tmr_reg <= 16'h0001)
        else $error("timer not restarted");
    AST_HOST_LVL: assert property (cfg_ok && src_reg[1:0] == `SQE_SRC_HOST
        |=> prog_out_lvl[0] == $past(host_reg[0]))
        else $error("host level not driven");
    AST_PRE_CFG: assert property (!cfg_ok
        |=> prog_out_oe == 10'h000 && prog_out_weak_pd == 10'h3FF && prog_out_lvl == 10'h000)
        else $error("output driven before config");
    AST_NO_CP_HIGH: assert property (prog_out_style[20:18] != `SQE_STY_CP
        && prog_out_style[23:21] != `SQE_STY_CP && prog_out_style[26:24] != `SQE_STY_CP
        && prog_out_style[29:27] != `SQE_STY_CP)
        else $error("charge pump on upper output");
    AST_OSC_TOGGLE: assert property (tick
        |=> osc_reg != $past(osc_reg) && tick_cnt == 12'h000)
        else $error("oscillator not toggling");

    COV_MON: cover property (fsm_reg == sqe_pkg::SQE_RUN && mon_fire);
    COV_TO: cover property (fsm_reg == sqe_pkg::SQE_RUN && !mon_fire && to_fire);
    COV_SEQ: cover property (fsm_reg == sqe_pkg::SQE_RUN && seq_fire && !jump_reg);
    COV_JUMP: cover property (fsm_reg == sqe_pkg::SQE_RUN && jump_reg);

endmodule // sqe_engine

`default_nettype wire

// File: test/sqe_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

module sqe_supply_model #(
    parameter int DLY = 8
) (
    // Clock
    input  wire logic       mclk,
    // Enables from the engine and injected faults
    input  wire logic [9:0] en,
    input  wire logic [9:0] fault,
    // Filtered status back to the engine
    output logic      [9:0] status
);
    // ==========================================
    // Converters come up late; a short drops them at once
    logic [9:0] ramp_reg [DLY];

    always_ff @(posedge mclk) begin
        ramp_reg[0] <= en;
        for (int i = 1; i < DLY; i++) begin
            ramp_reg[i] <= ramp_reg[i-1];
        end
    end

    assign status = ramp_reg[DLY-1] & ~fault;
endmodule // sqe_supply_model

`default_nettype wire

// File: test/supply_sequencing_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sqe_regs.svh"

module supply_sequencing_engine_tb;
    // ==========================================
    // Signals
    logic        mclk;
    logic        rstn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [9:0]  sfd_status;
    logic [5:0]  warn_in;
    logic        config_done;
    logic [9:0]  fault;
    logic [9:0]  prog_out_lvl;
    logic [9:0]  prog_out_oe;
    logic [9:0]  prog_out_weak_pd;
    logic [29:0] prog_out_style;
    logic [31:0] rdat;
    int          n_mismatch;
    int          comparisons;
    int          cycles;
    int          n;

    typedef struct packed {
        logic       warn;
        logic       jmp;
        logic       fast;
        logic [9:0] flt;
        logic [5:0] st;
        logic [9:0] lvl;
    } sqe_row_s;
    sqe_row_s rows [14];

    // ==========================================
    // Design and supplies
    sqe_engine i_sqe_engine (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sfd_status(sfd_status), .warn_in(warn_in), .config_done(config_done),
        .prog_out_lvl(prog_out_lvl), .prog_out_oe(prog_out_oe),
        .prog_out_weak_pd(prog_out_weak_pd), .prog_out_style(prog_out_style)
    );

    sqe_supply_model i_sqe_supply_model (
        .mclk(mclk), .en(prog_out_lvl), .fault(fault), .status(sfd_status)
    );

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    // Rows need about 36000 cycles at worst; ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ==========================================
    // Tasks
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Gap cycle after each strobe so no strobe is set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
        @(posedge mclk);
    endtask

    function automatic sqe_pkg::sqe_def_s mk(
        input logic [9:0] o, input logic [10:0] sm, input logic [5:0] sn,
        input logic [15:0] sd, input logic [10:0] mm, input logic [5:0] mn,
        input logic te, input logic [15:0] td, input logic [5:0] tn);
        mk = '{to_en: te, to_dly: td, to_next: tn, mon_next: mn, mon_pol: 1'h1,
               mon_mask: mm, seq_next: sn, seq_dly: sd, seq_pol: 1'h1,
               seq_mask: sm, outs: o};
    endfunction

    task automatic load_def(input logic [5:0] idx, input sqe_pkg::sqe_def_s d);
        wr(`SQE_A_MEMW0, d[31:0]);
        wr(`SQE_A_MEMW1, d[63:32]);
        wr(`SQE_A_MEMW2, {11'h000, d[84:64]});
        wr(`SQE_A_MEMADDR, {26'h0000000, idx});
    endtask

    // ==========================================
    // Main sequence
    initial begin
        rstn = 1'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        warn_in = 6'h00;
        config_done = 1'h0;
        fault = 10'h000;
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        rows = '{
            '{1'h0, 1'h0, 1'h0, 10'h000, 6'h01, 10'h003},
            '{1'h0, 1'h0, 1'h0, 10'h000, 6'h02, 10'h2A7},
            '{1'h1, 1'h0, 1'h0, 10'h000, 6'h05, 10'h0F0},
            '{1'h0, 1'h1, 1'h0, 10'h000, 6'h00, 10'h001},
            '{1'h0, 1'h0, 1'h0, 10'h000, 6'h01, 10'h003},
            '{1'h0, 1'h0, 1'h0, 10'h000, 6'h02, 10'h2A7},
            '{1'h0, 1'h0, 1'h1, 10'h002, 6'h03, 10'h100},
            '{1'h0, 1'h1, 1'h0, 10'h002, 6'h00, 10'h001},
            '{1'h0, 1'h0, 1'h0, 10'h002, 6'h01, 10'h003},
            '{1'h0, 1'h0, 1'h0, 10'h002, 6'h04, 10'h200},
            '{1'h0, 1'h1, 1'h0, 10'h000, 6'h00, 10'h001},
            '{1'h0, 1'h0, 1'h0, 10'h000, 6'h01, 10'h003},
            '{1'h0, 1'h0, 1'h0, 10'h000, 6'h02, 10'h2A7},
            '{1'h1, 1'h0, 1'h1, 10'h001, 6'h03, 10'h100}};
        repeat (16) @(posedge mclk);
        rstn <= 1'h1;
        repeat (4) @(posedge mclk);
        chk({22'h000000, prog_out_weak_pd}, 32'h000003FF);
        chk({22'h000000, prog_out_lvl}, 32'h00000000);
        load_def(6'h00, mk(10'h001, 11'h001, 6'h01, 16'h0002, 11'h000, 6'h00, 1'h0, 16'h0000, 6'h00));
        load_def(6'h01, mk(10'h003, 11'h002, 6'h02, 16'h0000, 11'h001, 6'h03, 1'h1, 16'h0005, 6'h04));
        load_def(6'h02, mk(10'h2A7, 11'h400, 6'h05, 16'h0000, 11'h003, 6'h03, 1'h0, 16'h0000, 6'h00));
        load_def(6'h03, mk(10'h100, 11'h000, 6'h00, 16'h9C40, 11'h000, 6'h00, 1'h0, 16'h0000, 6'h00));
        load_def(6'h04, mk(10'h200, 11'h000, 6'h00, 16'h9C40, 11'h000, 6'h00, 1'h0, 16'h0000, 6'h00));
        load_def(6'h05, mk(10'h0F0, 11'h000, 6'h00, 16'h9C40, 11'h000, 6'h00, 1'h0, 16'h0000, 6'h00));
        config_done <= 1'h1;
        for (int i = 0; i < 14; i++) begin
            warn_in <= {5'h00, rows[i].warn};
            fault <= rows[i].flt;
            if (rows[i].jmp) begin
                wr(`SQE_A_JUMP, 32'h00000001);
            end
            n = 0;
            while (prog_out_lvl !== rows[i].lvl && n < 30000) begin
                @(posedge mclk);
                n++;
            end
            chk({22'h000000, prog_out_lvl}, {22'h000000, rows[i].lvl});
            rd(`SQE_A_STAT, rdat);
            chk({26'h0000000, rdat[5:0]}, {26'h0000000, rows[i].st});
            if (rows[i].fast) begin
                chk({31'h00000000, (n < 5000)}, 32'h00000001);
            end
        end
        // Output sources: out0 from host, out1 from oscillator
        wr(`SQE_A_HOST, 32'h00000001);
        wr(`SQE_A_SRC, 32'h00000009);
        repeat (4) @(posedge mclk);
        chk({31'h00000000, prog_out_lvl[0]}, 32'h00000001);
        chk({24'h000000, prog_out_lvl[9:2]}, 32'h00000040);
        n = 0;
        #1;
        rdat[0] = prog_out_lvl[1];
        repeat (`SQE_TICK_CYC) begin
            @(posedge mclk);
            #1;
            if (prog_out_lvl[1] !== rdat[0]) begin
                n++;
                rdat[0] = prog_out_lvl[1];
            end
        end
        chk(n, 32'h00000002);
        @(posedge mclk);
        wr(`SQE_A_HOST, 32'h00000000);
        repeat (4) @(posedge mclk);
        chk({31'h00000000, prog_out_lvl[0]}, 32'h00000000);
        // Charge pump only legal on the first six outputs
        wr(`SQE_A_STYLE, 32'h00120002);
        repeat (4) @(posedge mclk);
        chk({2'h0, prog_out_style}, 32'h00020002);
        chk({31'h00000000, prog_out_oe[0]}, 32'h00000001);
        chk({22'h000000, prog_out_weak_pd}, 32'h00000000);
        rd(8'hFC, rdat);
        chk(rdat, 32'h00000000);
        complete_run();
    end
endmodule // supply_sequencing_engine_tb

`default_nettype wire
